// *** ext_irq_and_debug_pin_control.sv ***
// external pin interrupt and debug pin control, with register slave
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Configuration bit 8 turns on digital filtering for that line.
// - Mode field bits 7:5: 0 off, 1 rise, 2 fall, 3 both edges.
// - Mode 4 high level, 5 low level; software avoids codes 6 and 7.
// - Pending flags D, C, A in bits 3, 2, 0; write one clears.
// - Debug disable bit 5 blocks debug activation unless already active.
// - Bit 4 lets regulator enable drive port A pin 7; on after reset.
// - Status bit 3 holds inverted boot-select pin caught after reset.
// - Status bit 1 shows debugger forced active by cable; read only.
// - Status bit 0 shows two-wire debug enabled by access port.
// - Lines C and D take their pin from a five-bit select field.
module ext_irq_and_debug_pin_control
    import ext_irq_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register bus write
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // register bus read
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins
    input wire logic extLineA,
    input wire logic extLineB,
    input wire logic [31:0] portPins,
    input wire logic bootSelectPinN,
    // debug and regulator
    input wire logic debuggerCableForce,
    input wire logic debugPortEnable,
    input wire logic liveReservedLoad,
    input wire logic liveReservedValue,
    input wire logic regulatorEnable,
    input wire logic portAPin7Normal,
    output logic portAPin7Out,
    output logic debugActive,
    // interrupt
    output logic irq
);
    // ==========================================
    // address decode
    function automatic regSel_t regDecode(input logic [31:0] addr);
        case (addr)
            ADDR_PENDING: regDecode = SEL_PENDING;
            ADDR_CFG_A: regDecode = SEL_CFG_A;
            ADDR_CFG_B: regDecode = SEL_CFG_B;
            ADDR_CFG_C: regDecode = SEL_CFG_C;
            ADDR_CFG_D: regDecode = SEL_CFG_D;
            ADDR_DBG_CFG: regDecode = SEL_DBG_CFG;
            ADDR_DBG_STAT: regDecode = SEL_DBG_STAT;
            ADDR_SEL_C: regDecode = SEL_PIN_C;
            ADDR_SEL_D: regDecode = SEL_PIN_D;
            ADDR_IRQ_STATUS: regDecode = SEL_IRQ_STATUS;
            ADDR_IRQ_ENABLE: regDecode = SEL_IRQ_ENABLE;
            ADDR_IRQ_CLEAR: regDecode = SEL_IRQ_CLEAR;
            default: regDecode = SEL_NONE;
        endcase
    endfunction : regDecode

    logic awHave_q;
    logic wHave_q;
    logic [31:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic writeFire;
    logic lowLane;
    regSel_t wrSel;
    rdState_t rdState_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [31:0] readWord;

    logic [3:0] cfgFilt_q;
    logic [2:0] cfgMode_q [4];
    logic [4:0] selC_q;
    logic [4:0] selD_q;
    logic [3:0] pending_q;
    logic [3:0] irqStatus_q;
    logic [3:0] irqEnable_q;
    logic irq_q;
    logic dbgDisable_q;
    logic regOverride_q;
    logic liveRsvd_q;
    logic debugActive_q;
    logic bootStatus_q;
    logic bootTaken_q;
    logic forced_q;
    logic swEnabled_q;
    logic pin7_q;
    logic [3:0] lineEvent;
    logic [3:0] lineRaw;

    // ==========================================
    // write channel: address and data in either order
    assign s_axi_awready = !awHave_q && !bvalid_q;
    assign s_axi_wready = !wHave_q && !bvalid_q;
    assign writeFire = awHave_q && wHave_q && !bvalid_q;
    assign wrSel = regDecode(awAddr_q);
    // all fields live in byte lane 0 except the filter bit 8, which uses lane 1
    assign lowLane = writeFire && wStrb_q[0];

    always_ff @(posedge clk) begin
        if (rst) begin
            awHave_q <= 1'b0;
            awAddr_q <= 32'h0000_0000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHave_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
        end else if (writeFire) begin
            awHave_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wHave_q <= 1'b0;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHave_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
        end else if (writeFire) begin
            wHave_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (writeFire) begin
            bvalid_q <= 1'b1;
            bresp_q <= (wrSel == SEL_NONE || wrSel == SEL_DBG_STAT) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // ==========================================
    // read channel
    always_comb begin
        readWord = 32'h0000_0000;
        case (regDecode(s_axi_araddr))
            SEL_PENDING: readWord[3:0] = pending_q;
            SEL_CFG_A: readWord[8:5] = {cfgFilt_q[LINE_A], cfgMode_q[LINE_A]};
            SEL_CFG_B: readWord[8:5] = {cfgFilt_q[LINE_B], cfgMode_q[LINE_B]};
            SEL_CFG_C: readWord[8:5] = {cfgFilt_q[LINE_C], cfgMode_q[LINE_C]};
            SEL_CFG_D: readWord[8:5] = {cfgFilt_q[LINE_D], cfgMode_q[LINE_D]};
            SEL_DBG_CFG: readWord[5:3] = {dbgDisable_q, regOverride_q, liveRsvd_q};
            SEL_DBG_STAT: readWord[3:0] = {bootStatus_q, 1'b0, forced_q, swEnabled_q};
            SEL_PIN_C: readWord[4:0] = selC_q;
            SEL_PIN_D: readWord[4:0] = selD_q;
            SEL_IRQ_STATUS: readWord[3:0] = irqStatus_q;
            SEL_IRQ_ENABLE: readWord[3:0] = irqEnable_q;
            default: readWord = 32'h0000_0000;
        endcase
    end

    assign s_axi_arready = (rdState_q == RD_IDLE);

    always_ff @(posedge clk) begin
        if (rst) begin
            rdState_q <= RD_IDLE;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else begin
            case (rdState_q)
                RD_IDLE: begin
                    if (s_axi_arvalid) begin
                        rdState_q <= RD_DATA;
                        rdata_q <= readWord;
                        rresp_q <= (regDecode(s_axi_araddr) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
                    end
                end
                RD_DATA: begin
                    if (s_axi_rready) begin
                        rdState_q <= RD_IDLE;
                    end
                end
                default: rdState_q <= RD_IDLE;
            endcase
        end
    end

    assign s_axi_rvalid = (rdState_q == RD_DATA);
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // ==========================================
    // line configuration and pin select
    always_ff @(posedge clk) begin
        if (rst) begin
            cfgFilt_q <= 4'h0;
            cfgMode_q <= '{default: MODE_OFF};
        end else if (lowLane || (writeFire && wStrb_q[1])) begin
            for (int i = 0; i < 4; i++) begin
                if (wrSel == regSel_t'(SEL_CFG_A + i)) begin
                    if (wStrb_q[1]) begin
                        cfgFilt_q[i] <= wData_q[CFG_FILT_BIT];
                    end
                    if (wStrb_q[0]) begin
                        cfgMode_q[i] <= wData_q[CFG_MODE_LSB +: 3];
                    end
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            selC_q <= SEL_C_RESET;
            selD_q <= SEL_D_RESET;
        end else if (lowLane && wrSel == SEL_PIN_C) begin
            selC_q <= wData_q[4:0];
        end else if (lowLane && wrSel == SEL_PIN_D) begin
            selD_q <= wData_q[4:0];
        end
    end

    // selectable source pins for C and D
    assign lineRaw = {portPins[selD_q], portPins[selC_q], extLineB, extLineA};

    // ==========================================
    // per-line filter and detector
    generate
        for (genvar g = 0; g < 4; g++) begin : gLine
            ext_line_if lineBus ();
            assign lineBus.filterEnable = cfgFilt_q[g];
            assign lineBus.triggerMode = cfgMode_q[g];
            assign lineBus.rawLevel = lineRaw[g];
            assign lineEvent[g] = lineBus.lineEvent;
            ext_line_filter uFilt (
                .clk(clk),
                .rst(rst),
                .line(lineBus)
            );
            ext_line_detect uDet (
                .clk(clk),
                .rst(rst),
                .line(lineBus)
            );
        end
    endgenerate

    // ==========================================
    // pending flags, set wins over clear
    // write one to clear, no line B flag
    // level modes set again after clear
    always_ff @(posedge clk) begin
        if (rst) begin
            pending_q <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (i != LINE_B) begin
                    pending_q[i] <= lineEvent[i] | (pending_q[i] & ~(lowLane && wrSel == SEL_PENDING && wData_q[i]));
                end else begin
                    pending_q[i] <= 1'b0;
                end
            end
        end
    end

    // ==========================================
    // interrupt status, enable and clear
    always_ff @(posedge clk) begin
        if (rst) begin
            irqStatus_q <= 4'h0;
            irqEnable_q <= 4'h0;
            irq_q <= 1'b0;
        end else begin
            irqStatus_q <= lineEvent | (irqStatus_q & ~((lowLane && wrSel == SEL_IRQ_CLEAR) ? wData_q[3:0] : 4'h0));
            if (lowLane && wrSel == SEL_IRQ_ENABLE) begin
                irqEnable_q <= wData_q[3:0];
            end
            irq_q <= |(irqStatus_q & irqEnable_q);
        end
    end

    assign irq = irq_q;

    // ==========================================
    // debug configuration
    // regulator override on after reset
    // reserved bit may change under hardware
    always_ff @(posedge clk) begin
        if (rst) begin
            dbgDisable_q <= DBG_CFG_RESET[DBG_DIS_BIT];
            regOverride_q <= DBG_CFG_RESET[DBG_REG_BIT];
            liveRsvd_q <= DBG_CFG_RESET[DBG_RSVD_BIT];
        end else begin
            if (lowLane && wrSel == SEL_DBG_CFG) begin
                dbgDisable_q <= wData_q[DBG_DIS_BIT];
                regOverride_q <= wData_q[DBG_REG_BIT];
            end
            if (liveReservedLoad) begin
                liveRsvd_q <= liveReservedValue;
            end else if (lowLane && wrSel == SEL_DBG_CFG) begin
                liveRsvd_q <= wData_q[DBG_RSVD_BIT];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            debugActive_q <= 1'b0;
        end else begin
            debugActive_q <= (debuggerCableForce | debugPortEnable) & (debugActive_q | ~dbgDisable_q);
        end
    end

    assign debugActive = debugActive_q;

    // pin 7 driven by regulator enable
    always_ff @(posedge clk) begin
        if (rst) begin
            pin7_q <= 1'b0;
        end else begin
            pin7_q <= regOverride_q ? regulatorEnable : portAPin7Normal;
        end
    end

    assign portAPin7Out = pin7_q;

    // ==========================================
    // debug status
    // boot select caught once after reset release
    always_ff @(posedge clk) begin
        if (rst) begin
            bootTaken_q <= 1'b0;
            bootStatus_q <= 1'b0;
        end else if (!bootTaken_q) begin
            bootTaken_q <= 1'b1;
            bootStatus_q <= ~bootSelectPinN;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            forced_q <= 1'b0;
            swEnabled_q <= 1'b0;
        end else begin
            forced_q <= debuggerCableForce;
            swEnabled_q <= debugPortEnable;
        end
    end

    // ==========================================
    // checks
    property p_pend_set;
        @(posedge clk) disable iff (rst)
        (lineEvent[LINE_A]) |=> pending_q[LINE_A];
    endproperty
    a_pend_set: assert property (p_pend_set) else $error("line A event lost");

    property p_pend_clear;
        @(posedge clk) disable iff (rst)
        (lowLane && wrSel == SEL_PENDING && wData_q[LINE_D] && !lineEvent[LINE_D]) |=> !pending_q[LINE_D];
    endproperty
    a_pend_clear: assert property (p_pend_clear) else $error("line D flag not cleared");

    property p_level_reset;
        @(posedge clk) disable iff (rst)
        (cfgMode_q[LINE_C] == MODE_HIGH && gLine[LINE_C].lineBus.cleanLevel) |=> pending_q[LINE_C];
    endproperty
    a_level_reset: assert property (p_level_reset) else $error("level flag not held");

    property p_dbg_block;
        @(posedge clk) disable iff (rst)
        (dbgDisable_q && !debugActive_q) |=> !debugActive_q;
    endproperty
    a_dbg_block: assert property (p_dbg_block) else $error("debug activated while disabled");

    property p_reg_pin;
        @(posedge clk) disable iff (rst)
        (regOverride_q) |=> (portAPin7Out == $past(regulatorEnable));
    endproperty
    a_reg_pin: assert property (p_reg_pin) else $error("pin 7 not following regulator");

    property p_boot_hold;
        @(posedge clk) disable iff (rst)
        (bootTaken_q && $past(bootTaken_q)) |-> $stable(bootStatus_q);
    endproperty
    a_boot_hold: assert property (p_boot_hold) else $error("boot status changed");

    property p_forced;
        @(posedge clk) disable iff (rst)
        debuggerCableForce ##1 debuggerCableForce |-> forced_q;
    endproperty
    a_forced: assert property (p_forced) else $error("forced status missing");

    property p_irq_out;
        @(posedge clk) disable iff (rst)
        (|(irqStatus_q & irqEnable_q)) |=> irq;
    endproperty
    a_irq_out: assert property (p_irq_out) else $error("interrupt not raised");
endmodule : ext_irq_and_debug_pin_control
`default_nettype wire

// *** ext_irq_pkg.sv ***
// shared constants for the external interrupt and debug pin block
`default_nettype none
package ext_irq_pkg;
    // ==========================================
    // register byte addresses
    localparam logic [31:0] ADDR_PENDING = 32'h4000_A814;
    localparam logic [31:0] ADDR_CFG_A = 32'h4000_A860;
    localparam logic [31:0] ADDR_CFG_B = 32'h4000_A864;
    localparam logic [31:0] ADDR_CFG_C = 32'h4000_A868;
    localparam logic [31:0] ADDR_CFG_D = 32'h4000_A86C;
    localparam logic [31:0] ADDR_DBG_CFG = 32'h4000_BC00;
    localparam logic [31:0] ADDR_DBG_STAT = 32'h4000_BC04;
    localparam logic [31:0] ADDR_SEL_C = 32'h4000_BC14;
    localparam logic [31:0] ADDR_SEL_D = 32'h4000_BC18;
    localparam logic [31:0] ADDR_IRQ_STATUS = 32'h4000_BC20;
    localparam logic [31:0] ADDR_IRQ_ENABLE = 32'h4000_BC24;
    localparam logic [31:0] ADDR_IRQ_CLEAR = 32'h4000_BC28;
    // ==========================================
    // field positions
    localparam int CFG_FILT_BIT = 8;
    localparam int CFG_MODE_LSB = 5;
    localparam int DBG_DIS_BIT = 5;
    localparam int DBG_REG_BIT = 4;
    localparam int DBG_RSVD_BIT = 3;
    localparam int STAT_BOOT_BIT = 3;
    localparam int STAT_FORCE_BIT = 1;
    localparam int STAT_SWEN_BIT = 0;
    localparam int LINE_A = 0;
    localparam int LINE_B = 1;
    localparam int LINE_C = 2;
    localparam int LINE_D = 3;
    // ==========================================
    // reset values
    localparam logic [4:0] SEL_C_RESET = 5'h0F;
    localparam logic [4:0] SEL_D_RESET = 5'h10;
    localparam logic [7:0] DBG_CFG_RESET = 8'h10;
    // ==========================================
    // trigger modes
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_RISE = 3'h1;
    localparam logic [2:0] MODE_FALL = 3'h2;
    localparam logic [2:0] MODE_BOTH = 3'h3;
    localparam logic [2:0] MODE_HIGH = 3'h4;
    localparam logic [2:0] MODE_LOW = 3'h5;
    // ==========================================
    // timing and bus answers
    localparam logic [1:0] FILT_LAST = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================
    // register select and read state
    typedef enum logic [3:0] {
        SEL_PENDING, SEL_CFG_A, SEL_CFG_B, SEL_CFG_C, SEL_CFG_D, SEL_DBG_CFG, SEL_DBG_STAT,
        SEL_PIN_C, SEL_PIN_D, SEL_IRQ_STATUS, SEL_IRQ_ENABLE, SEL_IRQ_CLEAR, SEL_NONE
    } regSel_t;
    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_DATA = 2'b10
    } rdState_t;
endpackage : ext_irq_pkg
`default_nettype wire

// *** ext_line_if.sv ***
// signals shared between the control block and one line's filter and detector
`timescale 1ns/10ps
`default_nettype none
interface ext_line_if;
    logic filterEnable;
    logic [2:0] triggerMode;
    logic rawLevel;
    logic cleanLevel;
    logic lineEvent;
    modport filt (input filterEnable, input rawLevel, output cleanLevel);
    modport det (input triggerMode, input cleanLevel, output lineEvent);
    modport ctrl (output filterEnable, output triggerMode, output rawLevel, input cleanLevel, input lineEvent);
endinterface : ext_line_if
`default_nettype wire

// *** ext_line_filter.sv ***
// synchroniser and glitch filter for one external line
`timescale 1ns/10ps
`default_nettype none
module ext_line_filter
    import ext_irq_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // line
    ext_line_if.filt line
);
    logic sync1_q;
    logic sync2_q;
    logic clean_q;
    logic [1:0] cnt_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= line.rawLevel;
            sync2_q <= sync1_q;
        end
    end

    // ==========================================
    // stable-count filter
    // filter when enabled
    always_ff @(posedge clk) begin
        if (rst) begin
            clean_q <= 1'b0;
            cnt_q <= 2'h0;
        end else if (!line.filterEnable || sync2_q == clean_q) begin
            clean_q <= line.filterEnable ? clean_q : sync2_q;
            cnt_q <= 2'h0;
        end else if (cnt_q == FILT_LAST) begin
            clean_q <= sync2_q;
            cnt_q <= 2'h0;
        end else begin
            cnt_q <= cnt_q + 2'h1;
        end
    end

    assign line.cleanLevel = clean_q;

    property p_filt_stable;
        @(posedge clk) disable iff (rst)
        (line.filterEnable && $past(line.filterEnable) && clean_q != $past(clean_q))
            |-> ($past(sync2_q, 1) == clean_q && $past(sync2_q, 2) == clean_q && $past(sync2_q, 3) == clean_q);
    endproperty
    a_filt_stable: assert property (p_filt_stable) else $error("filtered level took a short pulse");
endmodule : ext_line_filter
`default_nettype wire

// *** ext_line_detect.sv ***
// edge and level trigger detection for one external line
`timescale 1ns/10ps
`default_nettype none
module ext_line_detect
    import ext_irq_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // line
    ext_line_if.det line
);
    logic prev_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= line.cleanLevel;
        end
    end

    // ==========================================
    // trigger select
    // edge and level modes
    always_comb begin
        case (line.triggerMode)
            MODE_RISE: line.lineEvent = line.cleanLevel & ~prev_q;
            MODE_FALL: line.lineEvent = ~line.cleanLevel & prev_q;
            MODE_BOTH: line.lineEvent = line.cleanLevel ^ prev_q;
            MODE_HIGH: line.lineEvent = line.cleanLevel;
            MODE_LOW: line.lineEvent = ~line.cleanLevel;
            default: line.lineEvent = 1'b0;
        endcase
    end

    property p_rise_only;
        @(posedge clk) disable iff (rst)
        (line.triggerMode == MODE_RISE && line.lineEvent) |-> (line.cleanLevel && !$past(line.cleanLevel));
    endproperty
    a_rise_only: assert property (p_rise_only) else $error("rising mode fired without a rise");

    property p_low_level;
        @(posedge clk) disable iff (rst)
        (line.triggerMode == MODE_LOW) |-> (line.lineEvent == !line.cleanLevel);
    endproperty
    a_low_level: assert property (p_low_level) else $error("low level mode mismatch");
endmodule : ext_line_detect
`default_nettype wire

// *** ext_irq_and_debug_pin_control_test.sv ***
// self-checking bench for the external interrupt and debug pin block
`timescale 1ns/10ps
`default_nettype none
module ext_irq_and_debug_pin_control_test;
    import ext_irq_pkg::*;
    // ==========================================
    // stimulus and observed signals
    logic clk = 0, rst = 1, awV = 0, wV = 0, bRdy = 0, arV = 0, rRdy = 0;
    logic [31:0] awA = '0, wD = '0, arA = '0, pins = '0, rData;
    logic lineA = 0, lineB = 0, bootN = 0, cable = 0, port = 0, rsvLd = 0, rsvV = 0, regEn = 0, pinNorm = 0;
    logic awRdy, wRdy, bV, arRdy, rV, pin7, dbgAct, irq;
    logic [1:0] bResp, rResp, resp;
    int errTotal = 0, numChecks = 0;
    ext_irq_and_debug_pin_control DUT (.clk(clk), .rst(rst), .s_axi_awaddr(awA), .s_axi_awvalid(awV),
        .s_axi_awready(awRdy), .s_axi_wdata(wD), .s_axi_wstrb(4'hF), .s_axi_wvalid(wV), .s_axi_wready(wRdy),
        .s_axi_bresp(bResp), .s_axi_bvalid(bV), .s_axi_bready(bRdy), .s_axi_araddr(arA), .s_axi_arvalid(arV),
        .s_axi_arready(arRdy), .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rV), .s_axi_rready(rRdy),
        .extLineA(lineA), .extLineB(lineB), .portPins(pins), .bootSelectPinN(bootN), .debuggerCableForce(cable),
        .debugPortEnable(port), .liveReservedLoad(rsvLd), .liveReservedValue(rsvV), .regulatorEnable(regEn),
        .portAPin7Normal(pinNorm), .portAPin7Out(pin7), .debugActive(dbgAct), .irq(irq));
    initial begin
        forever #25 clk = ~clk;
    end
    // ==========================================
    // bus and compare helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            errTotal++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // hold each channel until its own handshake edge
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        @(posedge clk);
        {awA, wD, awV, wV, bRdy} <= {a, d, 3'b111};
        // no cycle limit: only the watchdog ends a stuck wait
        do begin
            @(negedge clk);
            {ta, tw, tb} = {awV && awRdy, wV && wRdy, bV && bRdy};
            if (tb) resp = bResp;
            @(posedge clk);
            if (ta) awV <= 1'b0;
            if (tw) wV <= 1'b0;
            if (tb) bRdy <= 1'b0;
        end while (!tb);
    endtask : wr
    task automatic rc(input logic [31:0] a, input logic [31:0] exp);
        logic ta, tb;
        @(posedge clk);
        {arA, arV, rRdy} <= {a, 2'b11};
        do begin
            @(negedge clk);
            {ta, tb} = {arV && arRdy, rV && rRdy};
            // data taken while it stands, before the accepting edge
            if (tb) begin
                resp = rResp;
                chk(rData, exp);
            end
            @(posedge clk);
            if (ta) arV <= 1'b0;
            if (tb) rRdy <= 1'b0;
        end while (!tb);
    endtask : rc
    // ==========================================
    // scenarios
    task automatic t_edges;
        logic [2:0] m [4] = '{MODE_OFF, MODE_FALL, MODE_RISE, MODE_BOTH};
        rc(ADDR_DBG_CFG, 32'h10);
        rc(ADDR_DBG_STAT, 32'h8);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CFG_A, 32'(m[i]) << 5);
            rc(ADDR_CFG_A, 32'(m[i]) << 5);
            wr(ADDR_PENDING, 32'hF);
            lineA <= ~lineA;
            repeat (8) @(posedge clk);
            rc(ADDR_PENDING, (i > 0) ? 32'h1 : 32'h0);
        end
        wr(ADDR_PENDING, 32'h0);
        rc(ADDR_PENDING, 32'h1);
        wr(ADDR_CFG_B, 32'h60);
        lineB <= 1'b1;
        wr(ADDR_PENDING, 32'h1);
        repeat (8) @(posedge clk);
        rc(ADDR_PENDING, 32'h0);
        $display("edge modes done");
    endtask : t_edges
    task automatic t_level;
        pins[15] <= 1'b1;
        wr(ADDR_CFG_C, 32'h80);
        repeat (8) @(posedge clk);
        wr(ADDR_PENDING, 32'h4);
        rc(ADDR_PENDING, 32'h4);
        pins[15] <= 1'b0;
        wr(ADDR_CFG_C, 32'hA0);
        repeat (8) @(posedge clk);
        wr(ADDR_PENDING, 32'h4);
        rc(ADDR_PENDING, 32'h4);
        pins[3] <= 1'b1;
        wr(ADDR_SEL_C, 32'h3);
        rc(ADDR_SEL_C, 32'h3);
        repeat (8) @(posedge clk);
        wr(ADDR_PENDING, 32'h4);
        rc(ADDR_PENDING, 32'h0);
        wr(ADDR_CFG_C, 32'h0);
        wr(ADDR_PENDING, 32'hF);
        wr(ADDR_CFG_D, 32'h120);
        pins[16] <= 1'b1;
        repeat (2) @(posedge clk);
        pins[16] <= 1'b0;
        repeat (14) @(posedge clk);
        rc(ADDR_PENDING, 32'h0);
        pins[16] <= 1'b1;
        repeat (14) @(posedge clk);
        rc(ADDR_PENDING, 32'h8);
        $display("level and filter done");
    endtask : t_level
    task automatic t_irq;
        wr(ADDR_IRQ_CLEAR, 32'hF);
        lineA <= ~lineA;
        repeat (8) @(negedge clk);
        chk(irq, 1'b0); // masked until enabled
        rc(ADDR_IRQ_STATUS, 32'h1);
        wr(ADDR_IRQ_ENABLE, 32'h1);
        rc(ADDR_IRQ_ENABLE, 32'h1);
        repeat (3) @(negedge clk);
        chk(irq, 1'b1);
        wr(ADDR_IRQ_CLEAR, 32'h1);
        repeat (3) @(negedge clk);
        chk(irq, 1'b0);
        rc(32'h4000_BC30, 32'h0);
        chk(resp, RESP_SLVERR);
        $display("interrupt done");
    endtask : t_irq
    task automatic t_debug;
        {cable, regEn} <= 2'b11;
        repeat (4) @(negedge clk);
        chk(dbgAct, 1'b1);
        chk(pin7, 1'b1);
        wr(ADDR_DBG_STAT, 32'h0);
        chk(resp, RESP_SLVERR);
        rc(ADDR_DBG_STAT, 32'hA);
        port <= 1'b1;
        rc(ADDR_DBG_STAT, 32'hB);
        port <= 1'b0;
        // disabling while active must not drop the session
        wr(ADDR_DBG_CFG, 32'h20);
        @(negedge clk);
        chk(dbgAct, 1'b1);
        cable <= 1'b0;
        @(posedge clk);
        cable <= 1'b1;
        repeat (4) @(negedge clk);
        chk(dbgAct, 1'b0);
        chk(pin7, 1'b0);
        {rsvLd, rsvV} <= 2'b11;
        @(posedge clk);
        rsvLd <= 1'b0;
        rc(ADDR_DBG_CFG, 32'h28);
        $display("debug done");
    endtask : t_debug
    // ==========================================
    // verdict and run control
    task automatic finishTest;
        $display("checks %0d mismatches %0d", numChecks, errTotal);
        if (errTotal == 0 && numChecks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finishTest
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_edges();
        t_level();
        t_irq();
        t_debug();
        finishTest();
    end
    // whole run needs a few hundred cycles
    initial begin
        #2000000;
        errTotal++;
        finishTest();
    end
endmodule : ext_irq_and_debug_pin_control_test
`default_nettype wire
